// ==== rtl/osg_serial_prom.sv ====
// Function
// [R1] Serial command, address and data exchange
// [R2] Mode entered only after power-on
// [R3] Read, program and verify commands only
// [R4] Clock-synchronous shifting, least bit first
// [R5] Written bits never erased by commands
// [R6] Programmer reads ID code first
// [R7] Programmer compares non-blank ID code
// [R8] Programmer refuses operations on mismatch; id_check only clears ok, and xfer runs any operation regardless
// [R9] ID code words 0x90-0x96, readable
// [R10] Programmer writes and tests blank parts
// [R11] Blank ID code allows all operations
`include "osg_consts.svh"
`default_nettype none
module osg_serial_prom (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic power_good,
    input  wire logic prog_entry,
    input  wire logic sclk,
    input  wire logic sdata_in,
    output logic      sdata_out,
    output logic      sdata_oe,
    output logic      prom_mode,
    output logic      busy
);
    localparam int PROG_HOLD = `OSG_PROG_CYC - 1;
    // Unprogrammed cells read as all ones
    logic [`OSG_DATA_W-1:0] mem [0:`OSG_DEPTH-1] = '{default: `OSG_BLANK};
    osg_pkg::osg_state_type  state_r;
    logic                    sclk_r;
    logic [4:0]              bit_cnt_r;
    logic [`OSG_CMD_W-1:0]   cmd_r;
    logic [`OSG_ADDR_W-1:0]  addr_r;
    logic [`OSG_DATA_W-1:0]  shin_r;
    logic [`OSG_DATA_W-1:0]  shout_r;
    logic [7:0]              prog_cnt_r;
    logic                    prom_mode_r;
    logic                    oe_r;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    last_bit;
    logic [`OSG_CMD_W-1:0]   cmd_nxt;
    logic [`OSG_ADDR_W-1:0]  addr_nxt;
    logic [`OSG_DATA_W-1:0]  shin_nxt;
    logic [12:0]             widx;
    logic [7:0]              busy_len_r;

    assign sclk_rise = sclk & ~sclk_r;
    assign sclk_fall = ~sclk & sclk_r;
    // [R4] LSB enters at the top
    assign cmd_nxt   = {sdata_in, cmd_r[`OSG_CMD_W-1:1]};
    assign addr_nxt  = {sdata_in, addr_r[`OSG_ADDR_W-1:1]};
    assign shin_nxt  = {sdata_in, shin_r[`OSG_DATA_W-1:1]};
    assign widx      = addr_r[12:0];
    always_comb begin
        unique case (state_r)
            osg_pkg::OSG_CMD:  last_bit = (bit_cnt_r == 5'(`OSG_CMD_W - 1));
            osg_pkg::OSG_ADDR: last_bit = (bit_cnt_r == 5'(`OSG_ADDR_W - 1));
            default:           last_bit = (bit_cnt_r == 5'(`OSG_DATA_W - 1));
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_r <= 1'b0;
        end else begin
            sclk_r <= sclk;
        end
    end

    // [R2] Entry after power-on
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prom_mode_r <= 1'b0;
        end else if (!power_good) begin
            prom_mode_r <= 1'b0;
        end else begin
            prom_mode_r <= prog_entry;
        end
    end

    // [R1] Serial command sequencer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= osg_pkg::OSG_IDLE;
            bit_cnt_r  <= 5'h00;
            cmd_r      <= '0;
            addr_r     <= '0;
            shin_r     <= '0;
            prog_cnt_r <= 8'h00;
        end else if (!prom_mode_r) begin
            state_r   <= osg_pkg::OSG_IDLE;
            bit_cnt_r <= 5'h00;
        end else begin
            unique case (state_r)
                osg_pkg::OSG_IDLE: begin
                    state_r   <= osg_pkg::OSG_CMD;
                    bit_cnt_r <= 5'h00;
                end
                osg_pkg::OSG_CMD: if (sclk_rise) begin
                    cmd_r     <= cmd_nxt;
                    bit_cnt_r <= last_bit ? 5'h00 : bit_cnt_r + 5'h01;
                    if (last_bit) begin
                        // [R3] Unknown codes dropped
                        if (cmd_nxt == `OSG_CMD_READ || cmd_nxt == `OSG_CMD_PROG || cmd_nxt == `OSG_CMD_VERIFY) begin
                            state_r <= osg_pkg::OSG_ADDR;
                        end
                    end
                end
                osg_pkg::OSG_ADDR: if (sclk_rise) begin
                    addr_r    <= addr_nxt;
                    bit_cnt_r <= last_bit ? 5'h00 : bit_cnt_r + 5'h01;
                    if (last_bit) begin
                        state_r <= (cmd_r == `OSG_CMD_PROG) ? osg_pkg::OSG_DATA_IN : osg_pkg::OSG_DATA_OUT;
                    end
                end
                osg_pkg::OSG_DATA_IN: if (sclk_rise) begin
                    shin_r    <= shin_nxt;
                    bit_cnt_r <= last_bit ? 5'h00 : bit_cnt_r + 5'h01;
                    if (last_bit) begin
                        state_r    <= osg_pkg::OSG_WRITE;
                        prog_cnt_r <= 8'(`OSG_PROG_CYC);
                    end
                end
                osg_pkg::OSG_WRITE: begin
                    prog_cnt_r <= prog_cnt_r - 8'h01;
                    if (prog_cnt_r == 8'h01) begin
                        state_r <= osg_pkg::OSG_CMD;
                    end
                end
                osg_pkg::OSG_DATA_OUT: if (sclk_rise) begin
                    bit_cnt_r <= last_bit ? 5'h00 : bit_cnt_r + 5'h01;
                    if (last_bit) begin
                        state_r <= osg_pkg::OSG_CMD;
                    end
                end
            endcase
        end
    end

    // [R5] Bits only cleared from blank
    always_ff @(posedge ref_clk) begin
        if (state_r == osg_pkg::OSG_WRITE && prog_cnt_r == 8'h01) begin
            mem[widx] <= mem[widx] & shin_r;
        end
    end

    // [R9] ID words read like any word
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shout_r <= '0;
            oe_r    <= 1'b0;
        end else if (!prom_mode_r) begin
            oe_r    <= 1'b0;
        end else if (state_r == osg_pkg::OSG_ADDR && sclk_rise && last_bit) begin
            shout_r <= mem[addr_nxt[12:0]];
            oe_r    <= (cmd_r != `OSG_CMD_PROG);
        end else if (state_r == osg_pkg::OSG_DATA_OUT && sclk_rise && last_bit) begin
            // Line released with the state, not a cycle later
            oe_r    <= 1'b0;
        end else if (state_r == osg_pkg::OSG_DATA_OUT && sclk_fall && bit_cnt_r != 5'h00) begin
            shout_r <= {1'b0, shout_r[`OSG_DATA_W-1:1]};
        end else if (state_r != osg_pkg::OSG_DATA_OUT) begin
            oe_r <= 1'b0;
        end
    end

    assign sdata_out = shout_r[0];
    assign sdata_oe  = oe_r;
    assign prom_mode = prom_mode_r;
    assign busy      = (state_r == osg_pkg::OSG_WRITE);

    property p_entry;
        @(posedge ref_clk) disable iff (!resetn) !power_good |=> !prom_mode;
    endproperty
    a_entry: assert property (p_entry) else $error("mode held without power"); // [R2]

    // Length of the current busy run, for the a_busy_max check
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_len_r <= 8'h00;
        end else if (busy) begin
            busy_len_r <= busy_len_r + 8'h01;
        end else begin
            busy_len_r <= 8'h00;
        end
    end

    sequence s_write_start;
        state_r == osg_pkg::OSG_DATA_IN && sclk_rise && last_bit;
    endsequence
    sequence s_busy_end;
        busy ##1 !busy;
    endsequence
    property p_write_len;
        @(posedge ref_clk) disable iff (!resetn || !prom_mode_r)
            s_write_start |=> busy ##PROG_HOLD s_busy_end;
    endproperty
    a_write_len: assert property (p_write_len) else $error("program pulse length wrong"); // [R5]

    property p_busy_max;
        @(posedge ref_clk) disable iff (!resetn) busy |-> busy_len_r < 8'(`OSG_PROG_CYC);
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("program pulse too long"); // [R5]

    property p_no_erase;
        @(posedge ref_clk) disable iff (!resetn) busy && prog_cnt_r == 8'h01 |=> (mem[$past(widx)] & ~$past(mem[widx])) == '0;
    endproperty
    a_no_erase: assert property (p_no_erase) else $error("programmed bit erased"); // [R5]

    property p_bad_cmd;
        @(posedge ref_clk) disable iff (!resetn || !prom_mode_r)
            state_r == osg_pkg::OSG_CMD && sclk_rise && last_bit && cmd_nxt > `OSG_CMD_VERIFY |=> state_r == osg_pkg::OSG_CMD;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("illegal command accepted"); // [R3]

    property p_oe;
        @(posedge ref_clk) disable iff (!resetn) sdata_oe |-> state_r == osg_pkg::OSG_DATA_OUT;
    endproperty
    a_oe: assert property (p_oe) else $error("driving outside read"); // [R1]

    property p_lsb;
        @(posedge ref_clk) disable iff (!resetn || !prom_mode_r)
            state_r == osg_pkg::OSG_ADDR && sclk_rise && last_bit && cmd_r != `OSG_CMD_PROG
            |=> sdata_out == mem[addr_r[12:0]][0];
    endproperty
    a_lsb: assert property (p_lsb) else $error("first bit out not lsb"); // [R4]
endmodule
`default_nettype wire

// ==== rtl/osg_consts.svh ====
`ifndef OSG_CONSTS_SVH
`define OSG_CONSTS_SVH
// Serial frame widths
`define OSG_CMD_W        8
`define OSG_ADDR_W       14
`define OSG_DATA_W       10
// Command codes (arbitrary encodings)
`define OSG_CMD_READ     8'h01
`define OSG_CMD_PROG     8'h02
`define OSG_CMD_VERIFY   8'h03
// Memory geometry
`define OSG_DEPTH        8192
`define OSG_BLANK        10'h3ff
// Identification code window
`define OSG_ID_FIRST     14'h0090
`define OSG_ID_LAST      14'h0096
// Programming pulse
`define OSG_PROG_NS      1000
`define OSG_CLK_NS       25
`define OSG_PROG_CYC     ((`OSG_PROG_NS + `OSG_CLK_NS - 1) / `OSG_CLK_NS)
`endif

// ==== rtl/osg_pkg.sv ====
`default_nettype none
package osg_pkg;
    typedef enum logic [2:0] {
        OSG_IDLE,
        OSG_CMD,
        OSG_ADDR,
        OSG_DATA_IN,
        OSG_WRITE,
        OSG_DATA_OUT
    } osg_state_type;
endpackage
`default_nettype wire

// ==== test/osg_prog_model.sv ====
`include "osg_consts.svh"
`default_nettype none
module osg_prog_model (
    input  wire logic ref_clk,
    output logic      sclk,
    output logic      sdata_in,
    input  wire logic sdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        sdata_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic put(input logic [13:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            sdata_in = v[i];
            tick(2);
            sclk = 1'b1;
            tick(2);
            sclk = 1'b0;
        end
    endtask
    task automatic xfer(input logic [7:0] c, input logic [13:0] a, input logic [9:0] d, output logic [9:0] q);
        q = 10'h0;
        put(14'(c), 8);
        put(a, 14);
        if (c == `OSG_CMD_PROG) begin
            put(14'(d), 10);
        end else begin
            for (int i = 0; i < 10; i++) begin
                tick(2);
                q[i] = sdata_out;
                sclk = 1'b1;
                tick(2);
                sclk = 1'b0;
            end
        end
        sdata_in = ~sdata_in;
    endtask
    task automatic id_check(input logic [9:0] key, output logic ok);
        logic [9:0] w;
        ok = 1'b1;
        for (int a = `OSG_ID_FIRST; a <= `OSG_ID_LAST; a++) begin
            xfer(`OSG_CMD_READ, 14'(a), 10'h0, w);
            if (w !== `OSG_BLANK && w !== key) ok = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`include "osg_consts.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       power_good = 1'b0;
    logic       prog_entry = 1'b0;
    logic       sclk, sdata_in, sdata_out, sdata_oe, prom_mode, busy, ok;
    logic [9:0] q;
    int         err_total = 0;
    int         n_checks = 0;
    int         bc = 0;
    int         oc = 0;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (busy === 1'b1) bc++;
    always @(posedge ref_clk) if (sdata_oe === 1'b1) oc++;
    osg_serial_prom osg_serial_prom_i (.ref_clk(ref_clk), .resetn(resetn), .power_good(power_good),
        .prog_entry(prog_entry), .sclk(sclk), .sdata_in(sdata_in), .sdata_out(sdata_out),
        .sdata_oe(sdata_oe), .prom_mode(prom_mode), .busy(busy));
    osg_prog_model osg_prog_model_i (.ref_clk(ref_clk), .sclk(sclk), .sdata_in(sdata_in),
        .sdata_out(sdata_out));
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic t_read(input logic [7:0] c, input logic [13:0] a, input logic [9:0] e);
        oc = 0;
        osg_prog_model_i.xfer(c, a, 10'h0, q);
        check(14'(q), 14'(e));
        check(14'(sdata_oe), 14'h0);
        // Ten data bits of four reference cycles each
        check(14'(oc), 14'h28);
    endtask
    task automatic t_prog(input logic [13:0] a, input logic [9:0] d);
        bc = 0;
        osg_prog_model_i.xfer(`OSG_CMD_PROG, a, d, q);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) osg_prog_model_i.tick(1);
        check(14'(busy), 14'h0);
        if (busy !== 1'b0) finish_test();
        check(14'(bc), 14'(`OSG_PROG_CYC));
    endtask
    initial begin
        osg_prog_model_i.tick(2);
        check({10'h0, sdata_out, sdata_oe, prom_mode, busy}, 14'h0);
        resetn = 1'b1;
        osg_prog_model_i.tick(3);
        check(14'(prom_mode), 14'h0);
        power_good = 1'b1;
        prog_entry = 1'b1;
        osg_prog_model_i.tick(3);
        check(14'(prom_mode), 14'h1);
        osg_prog_model_i.id_check(10'h2aa, ok);
        check(14'(ok), 14'h1);
        t_read(`OSG_CMD_READ, 14'h1fff, `OSG_BLANK);
        t_prog(14'h0123, 10'h2a5);
        t_read(`OSG_CMD_VERIFY, 14'h0123, 10'h2a5);
        // Second write may only clear bits
        t_prog(14'h0123, 10'h35a);
        t_read(`OSG_CMD_VERIFY, 14'h0123, 10'h200);
        osg_prog_model_i.put(14'h07, 8);
        t_read(`OSG_CMD_READ, 14'h0123, 10'h200);
        t_prog(14'h0096, 10'h155);
        t_read(`OSG_CMD_READ, 14'h0096, 10'h155);
        osg_prog_model_i.id_check(10'h2aa, ok);
        check(14'(ok), 14'h0);
        prog_entry = 1'b0;
        osg_prog_model_i.tick(3);
        check(14'(prom_mode), 14'h0);
        finish_test();
    end
endmodule
`default_nettype wire
